// >>> verif/asfc_core_sva.sv
// asfc_core_sva: port-level checks for the serial frame core
// assumes: bound to asfc_core; tests run with a baud divisor of 4
`timescale 1ns/1ns
`default_nettype none
module asfc_core_sva (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  input wire asfc_pkg::asfc_cfg_t cfg,
  input wire logic module_on,
  input wire logic transmitter_on,
  input wire logic tx_output_invert,
  input wire logic pin_direction_control,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire asfc_pkg::asfc_word_t tx_holding_buffer,
  input wire logic tx_busy,
  input wire logic tx_pin_out,
  input wire logic tx_pin_oe,
  input wire logic rx_valid,
  input wire asfc_pkg::asfc_rx_t rx_holding_buffer
);
  import asfc_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  chk_pin_dir: assert property (tx_pin_oe == pin_direction_control)
    else $error("tx pin enable differs from direction");
  chk_idle_mark: assert property (!tx_busy && !$past(tx_busy) |-> tx_pin_out == !tx_output_invert)
    else $error("idle tx line not at mark");
  chk_start_space: assert property (tx_valid && tx_ready && clk_en |=> tx_busy && tx_pin_out == tx_output_invert)
    else $error("start bit not space after accept");
  chk_bit_period: assert property (tx_valid && tx_ready && clk_en && cfg.baud_divisor == 16'h0004
    |=> (tx_pin_out == tx_output_invert) [*4] ##1 (tx_pin_out ^ tx_output_invert) == $past(tx_holding_buffer.data[0], 5))
    else $error("start length or first data bit wrong");
  chk_busy_refuse: assert property (tx_busy |-> !tx_ready)
    else $error("ready while shifting");
  chk_tx_enable: assert property (!(module_on && transmitter_on) |-> !tx_ready)
    else $error("ready while transmitter off");
  chk_invert_now: assert property ($changed(tx_output_invert) && !tx_busy && !$past(tx_busy) && !$past(rst)
    |-> tx_pin_out != $past(tx_pin_out))
    else $error("invert did not flip tx pin");
  chk_parity_mode: assert property (rx_valid && rx_holding_buffer.parity_err
    |-> cfg.mode inside {ASFC_MODE_8EVEN, ASFC_MODE_8ODD})
    else $error("parity error outside parity mode");
endmodule
bind asfc_core asfc_core_sva u_asfc_core_sva (.mclk, .rst, .clk_en, .cfg, .module_on, .transmitter_on,
  .tx_output_invert, .pin_direction_control, .tx_valid, .tx_ready, .tx_holding_buffer, .tx_busy,
  .tx_pin_out, .tx_pin_oe, .rx_valid, .rx_holding_buffer);
`default_nettype wire

// >>> verif/asfc_remote.sv
// asfc_remote: behavioural far-end serial device
// assumes: bit period of div mclk cycles; tasks entered at a falling edge
`timescale 1ns/1ns
`default_nettype none
module asfc_remote (
  input wire logic mclk,
  input wire logic line_in,
  output logic line_out
);
  int div = 4;
  logic [10:0] got;
  initial line_out = 1'b1;
  task automatic send(input logic [10:0] f, input int n);
    for (int i = 0; i < n; i++)
    begin
      line_out = f[i];
      repeat (div) @(negedge mclk);
    end
    line_out = 1'b1;
  endtask
  // capture from start edge, mid bit
  task automatic grab(input int n);
    got = '0;
    @(negedge line_in);
    repeat (div / 2) @(negedge mclk);
    for (int i = 0; i < n; i++)
    begin
      got[i] = line_in;
      repeat (div) @(negedge mclk);
    end
  endtask
endmodule
`default_nettype wire

// >>> verif/testbench.sv
// testbench: frames in every mode both ways, errors, overrun, pin control
// assumes: asfc_remote on the line, divisor 4, inputs driven on falling edges
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import asfc_pkg::*;
  logic mclk, rst, clk_en, module_on, transmitter_on, receiver_on;
  logic tx_output_invert, pin_direction_control, tx_valid, tx_ready, tx_busy;
  logic tx_pin_out, tx_pin_oe, rx_line, rx_valid, rx_ready, rx_overrun;
  asfc_cfg_t cfg;
  asfc_word_t tx_holding_buffer;
  asfc_rx_t rx_holding_buffer;
  int failures = 0;
  int checks_done = 0;
  logic [10:0] f;
  int n;
  logic [7:0] pat [5] = '{8'hA5, 8'h3C, 8'h81, 8'h7E, 8'hC3};
  asfc_core u_asfc_core (.mclk, .rst, .clk_en, .cfg, .module_on, .transmitter_on, .receiver_on,
    .tx_output_invert, .pin_direction_control, .tx_valid, .tx_ready, .tx_holding_buffer, .tx_busy,
    .tx_pin_out, .tx_pin_oe, .rx_line, .rx_valid, .rx_ready, .rx_holding_buffer, .rx_overrun);
  asfc_remote u_asfc_remote (.mclk, .line_in(tx_pin_out), .line_out(rx_line));
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  function automatic int frame(input asfc_mode_t m, input logic [7:0] d, input logic a, input logic pe,
    input logic fe, output logic [10:0] fr);
    int nb;
    nb = (m == ASFC_MODE_7BIT) ? 7 : 8;
    fr = 11'h7FF;
    fr[0] = 1'b0;
    for (int i = 0; i < nb; i++)
      fr[i + 1] = d[i];
    if (m >= ASFC_MODE_8EVEN)
    begin
      fr[nb + 1] = (m == ASFC_MODE_8ADDR) ? a : ((^d) ^ (m == ASFC_MODE_8ODD) ^ pe);
      nb++;
    end
    fr[nb + 1] = ~fe;
    return nb + 2;
  endfunction
  task automatic put(input asfc_word_t w);
    tx_holding_buffer = w;
    tx_valid = 1'b1;
    do @(posedge mclk); while (tx_ready !== 1'b1);
    @(negedge mclk);
    tx_valid = 1'b0;
  endtask
  task automatic take(input logic [7:0] d, input logic a, input logic pe, input logic fe);
    logic adr;
    adr = (cfg.mode == ASFC_MODE_8ADDR);
    for (int k = 0; k < 40 && rx_valid !== 1'b1; k++)
      @(negedge mclk);
    check("rx_word", {rx_holding_buffer.word.ninth & adr, rx_holding_buffer.word.data}, {a & adr, d});
    check("rx_err", {rx_holding_buffer.framing_err, rx_holding_buffer.parity_err}, {fe, pe});
    rx_ready = 1'b1;
    @(negedge mclk);
    rx_ready = 1'b0;
  endtask
  initial
  begin
    repeat (20000) @(posedge mclk);
    failures++;
    give_verdict();
  end
  initial
  begin
    {rst, clk_en, module_on, transmitter_on, receiver_on, tx_output_invert} = 6'h30;
    {pin_direction_control, tx_valid, rx_ready} = 3'h4;
    cfg = '{ASFC_MODE_8BIT, 1'b0, 16'h0004};
    tx_holding_buffer = '0;
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    check("idle_pin", {tx_ready, tx_pin_out}, 16'h1);
    tx_output_invert = 1'b1;
    #1 check("inv_pin", tx_pin_out, 16'h0);
    pin_direction_control = 1'b0;
    #1 check("pin_oe", tx_pin_oe, 16'h0);
    @(negedge mclk);
    {tx_output_invert, pin_direction_control, module_on, transmitter_on, receiver_on} = 5'h0F;
    for (int m = 0; m < 5; m++)
    begin
      cfg.mode = asfc_mode_t'(m);
      n = frame(cfg.mode, pat[m], m[2], 1'b0, 1'b0, f);
      fork
        u_asfc_remote.grab(n);
        put({m[2], pat[m]});
      join
      check("tx_frame", u_asfc_remote.got & ((11'h1 << n) - 1), f & ((11'h1 << n) - 1));
      u_asfc_remote.send(f, n);
      take((m == 0) ? {1'b0, pat[0][6:0]} : pat[m], m[2], 1'b0, 1'b0);
    end
    cfg.mode = ASFC_MODE_8BIT;
    cfg.two_stop = 1'b1;
    put(9'h0C3);
    n = 0;
    while (tx_busy === 1'b1 && n < 100)
    begin
      n++;
      @(negedge mclk);
    end
    check("two_stop_len", n[15:0], 16'h002C);
    cfg.two_stop = 1'b0;
    cfg.mode = ASFC_MODE_8EVEN;
    n = frame(cfg.mode, 8'h5A, 1'b0, 1'b1, 1'b0, f);
    u_asfc_remote.send(f, n);
    take(8'h5A, 1'b0, 1'b1, 1'b0);
    cfg.mode = ASFC_MODE_8BIT;
    n = frame(cfg.mode, 8'h0F, 1'b0, 1'b0, 1'b1, f);
    u_asfc_remote.send(f, n);
    repeat (8) @(negedge mclk);
    take(8'h0F, 1'b0, 1'b0, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      n = frame(cfg.mode, pat[i], 1'b0, 1'b0, 1'b0, f);
      u_asfc_remote.send(f, n);
      repeat (4) @(negedge mclk);
      check("overrun", rx_overrun, {15'h0, i == 2});
    end
    take(pat[0], 1'b0, 1'b0, 1'b0);
    take(pat[1], 1'b0, 1'b0, 1'b0);
    check("rx_empty", rx_valid, 16'h0);
    give_verdict();
  end
endmodule
`default_nettype wire

// >>> verilog/asfc_core.sv
// asfc_core: asynchronous serial transmitter and receiver with one config
// assumes: rx_line already synchronous to mclk; tx pin sits behind an output enable
`timescale 1ns/1ns
`default_nettype none

module asfc_core (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  input wire asfc_pkg::asfc_cfg_t cfg,
  input wire logic module_on,
  input wire logic transmitter_on,
  input wire logic receiver_on,
  input wire logic tx_output_invert,
  input wire logic pin_direction_control,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire asfc_pkg::asfc_word_t tx_holding_buffer,
  output logic tx_busy,
  output logic tx_pin_out,
  output logic tx_pin_oe,
  input wire logic rx_line,
  output logic rx_valid,
  input wire logic rx_ready,
  output asfc_pkg::asfc_rx_t rx_holding_buffer,
  output logic rx_overrun
);
  import asfc_pkg::*;

  // ---------------------------------------------------------------
  // shared decode
  // ---------------------------------------------------------------
  // mode decode
  function automatic logic [3:0] data_bits(input asfc_mode_t m);
    data_bits = (m == ASFC_MODE_7BIT) ? ASFC_BITS_7 : ASFC_BITS_8;
  endfunction

  function automatic logic has_ninth(input asfc_mode_t m);
    has_ninth = (m == ASFC_MODE_8EVEN) || (m == ASFC_MODE_8ODD) || (m == ASFC_MODE_8ADDR);
  endfunction

  // even parity makes the count of ones even; odd makes it odd
  function automatic logic parity_of(input asfc_mode_t m, input logic [7:0] d, input logic addr);
    parity_of = (m == ASFC_MODE_8EVEN) ? ^d : (m == ASFC_MODE_8ODD) ? ~(^d) : addr;
  endfunction

  wire logic [ASFC_DIV_W-1:0] bit_period = (cfg.baud_divisor == ASFC_DIV_ZERO) ? ASFC_DIV_ONE : cfg.baud_divisor;
  wire logic [ASFC_DIV_W-1:0] half_period = {1'b0, bit_period[ASFC_DIV_W-1:1]};
  wire logic [3:0] nbits = data_bits(cfg.mode);
  wire logic ninth_on = has_ninth(cfg.mode);
  wire logic [1:0] nstop = cfg.two_stop ? ASFC_STOP_TWO : ASFC_STOP_ONE;
  wire logic tx_run = module_on && transmitter_on;
  wire logic rx_run = module_on && receiver_on;

  // ---------------------------------------------------------------
  // transmit path
  // ---------------------------------------------------------------
  asfc_state_t tx_state_reg, tx_state_next;
  logic [ASFC_DIV_W-1:0] tx_cnt_reg;
  logic [3:0] tx_bit_reg;
  logic [1:0] tx_stop_reg;
  logic [8:0] tx_shift_register;
  logic tx_line_reg;
  wire logic tx_tick = (tx_cnt_reg == ASFC_DIV_ONE);
  wire logic tx_load = (tx_state_reg == ASFC_IDLE) && tx_run && tx_valid;
  wire logic tx_last_data = (tx_bit_reg == nbits - 4'h1);
  wire logic tx_last_stop = (tx_stop_reg == nstop);

  assign tx_ready = (tx_state_reg == ASFC_IDLE) && tx_run;
  assign tx_busy = (tx_state_reg != ASFC_IDLE);

  always_comb
  begin
    tx_state_next = tx_state_reg;
    unique case (tx_state_reg)
      ASFC_IDLE: if (tx_load) tx_state_next = ASFC_START;
      ASFC_START: if (tx_tick) tx_state_next = ASFC_DATA;
      ASFC_DATA: if (tx_tick && tx_last_data) tx_state_next = ninth_on ? ASFC_NINTH : ASFC_STOP;
      ASFC_NINTH: if (tx_tick) tx_state_next = ASFC_STOP;
      ASFC_STOP: if (tx_tick && tx_last_stop) tx_state_next = ASFC_IDLE;
      default: tx_state_next = ASFC_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      tx_state_reg <= ASFC_IDLE;
      tx_cnt_reg <= ASFC_DIV_ZERO;
      tx_bit_reg <= 4'h0;
      tx_stop_reg <= 2'h0;
      tx_shift_register <= 9'h000;
      tx_line_reg <= 1'b1;
    end
    else if (clk_en)
    begin
      tx_state_reg <= tx_state_next;
      if (tx_load)
      begin
        tx_shift_register <= {parity_of(cfg.mode, tx_holding_buffer.data, tx_holding_buffer.ninth),
                              tx_holding_buffer.data};
        tx_cnt_reg <= bit_period;
        tx_bit_reg <= 4'h0;
        tx_stop_reg <= ASFC_STOP_ONE;
        tx_line_reg <= 1'b0;
      end
      else if (tx_state_reg != ASFC_IDLE)
      begin
        tx_cnt_reg <= tx_tick ? bit_period : tx_cnt_reg - ASFC_DIV_ONE;
        if (tx_tick)
        begin
          unique case (tx_state_next)
            ASFC_DATA:
            begin
              tx_line_reg <= tx_shift_register[0];
              if (tx_state_reg == ASFC_DATA)
              begin
                tx_bit_reg <= tx_bit_reg + 4'h1;
              end
            end
            ASFC_NINTH:
            begin
              tx_line_reg <= tx_shift_register[0];
            end
            ASFC_STOP:
            begin
              tx_line_reg <= 1'b1;
              if (tx_state_reg == ASFC_STOP)
              begin
                tx_stop_reg <= tx_stop_reg + 2'h1;
              end
            end
            default: tx_line_reg <= 1'b1;
          endcase
          // every tick, start included, moves the next bit down
          tx_shift_register <= {1'b0, tx_shift_register[8:1]};
        end
      end
      else
      begin
        tx_line_reg <= 1'b1;
      end
    end
  end

  // invert acts combinationally on the pin
  assign tx_pin_out = tx_line_reg ^ tx_output_invert;
  assign tx_pin_oe = pin_direction_control;

  // ---------------------------------------------------------------
  // receive path
  // ---------------------------------------------------------------
  asfc_state_t rx_state_reg, rx_state_next;
  logic [ASFC_DIV_W-1:0] rx_cnt_reg;
  logic [3:0] rx_bit_reg;
  logic [8:0] rx_shift_reg;
  logic rx_prev_reg;
  logic rx_push_reg;
  asfc_rx_t rx_word_reg;
  wire logic rx_tick = (rx_cnt_reg == ASFC_DIV_ONE);
  // start on falling edge of idle line
  wire logic rx_fall = rx_prev_reg && !rx_line;
  wire logic rx_last_data = (rx_bit_reg == nbits - 4'h1);
  wire logic [7:0] rx_data = (cfg.mode == ASFC_MODE_7BIT) ? {1'b0, rx_shift_reg[8:2]} : rx_shift_reg[8:1];
  // ninth-bit modes keep the data one place lower
  wire logic [7:0] rx_data_n = rx_shift_reg[7:0];
  // wait to mid start bit; never zero so the count still ends
  wire logic [ASFC_DIV_W-1:0] rx_first_wait = (half_period == ASFC_DIV_ZERO) ? ASFC_DIV_ONE : half_period;

  always_comb
  begin
    rx_state_next = rx_state_reg;
    unique case (rx_state_reg)
      ASFC_IDLE: if (rx_run && rx_fall) rx_state_next = ASFC_START;
      ASFC_START: if (rx_tick) rx_state_next = rx_line ? ASFC_IDLE : ASFC_DATA;
      ASFC_DATA: if (rx_tick && rx_last_data) rx_state_next = ninth_on ? ASFC_NINTH : ASFC_STOP;
      ASFC_NINTH: if (rx_tick) rx_state_next = ASFC_STOP;
      ASFC_STOP: if (rx_tick) rx_state_next = ASFC_IDLE;
      default: rx_state_next = ASFC_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rx_state_reg <= ASFC_IDLE;
      rx_cnt_reg <= ASFC_DIV_ZERO;
      rx_bit_reg <= 4'h0;
      rx_shift_reg <= 9'h000;
      rx_prev_reg <= 1'b1;
      rx_push_reg <= 1'b0;
      rx_word_reg <= '0;
    end
    else if (clk_en)
    begin
      rx_prev_reg <= rx_line;
      rx_state_reg <= rx_state_next;
      rx_push_reg <= 1'b0;
      if (rx_state_reg == ASFC_IDLE)
      begin
        // first sample at mid start bit
        rx_cnt_reg <= rx_first_wait;
        rx_bit_reg <= 4'h0;
      end
      else if (rx_tick)
      begin
        rx_cnt_reg <= bit_period;
        if (rx_state_reg == ASFC_DATA || rx_state_reg == ASFC_NINTH)
        begin
          rx_shift_reg <= {rx_line, rx_shift_reg[8:1]};
          rx_bit_reg <= rx_bit_reg + 4'h1;
        end
        if (rx_state_reg == ASFC_STOP)
        begin
          rx_push_reg <= 1'b1;
          rx_word_reg.framing_err <= !rx_line;
          rx_word_reg.parity_err <= ((cfg.mode == ASFC_MODE_8EVEN) || (cfg.mode == ASFC_MODE_8ODD)) &&
                                    (rx_shift_reg[8] != parity_of(cfg.mode, rx_data_n, 1'b0));
          rx_word_reg.word.data <= ninth_on ? rx_data_n : rx_data;
          rx_word_reg.word.ninth <= (cfg.mode == ASFC_MODE_8ADDR) && rx_shift_reg[8];
        end
      end
      else
      begin
        rx_cnt_reg <= rx_cnt_reg - ASFC_DIV_ONE;
      end
    end
  end

  // ---------------------------------------------------------------
  // two-entry receive buffer
  // ---------------------------------------------------------------
  asfc_rx_t rx_buf_reg [0:1];
  logic rx_wr_reg, rx_rd_reg;
  logic [1:0] rx_cnt_q_reg;
  wire logic rx_full = (rx_cnt_q_reg == 2'h2);
  wire logic rx_pop = rx_valid && rx_ready;
  wire logic rx_put = rx_push_reg && !rx_full;

  assign rx_valid = (rx_cnt_q_reg != 2'h0);
  assign rx_holding_buffer = rx_buf_reg[rx_rd_reg];

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rx_wr_reg <= 1'b0;
      rx_rd_reg <= 1'b0;
      rx_cnt_q_reg <= 2'h0;
      rx_overrun <= 1'b0;
      rx_buf_reg[0] <= '0;
      rx_buf_reg[1] <= '0;
    end
    else if (clk_en)
    begin
      if (rx_put)
      begin
        rx_buf_reg[rx_wr_reg] <= rx_word_reg;
        rx_wr_reg <= !rx_wr_reg;
      end
      if (rx_pop)
      begin
        rx_rd_reg <= !rx_rd_reg;
      end
      rx_cnt_q_reg <= rx_cnt_q_reg + {1'b0, rx_put} - {1'b0, rx_pop};
      // sticky until reset: a word arrived with both entries full
      if (rx_push_reg && rx_full)
      begin
        rx_overrun <= 1'b1;
      end
    end
  end
endmodule

`default_nettype wire

// >>> verilog/asfc_pkg.sv
// asfc_pkg: shared constants and types for the async serial frame core
// assumes: single clock domain, no register bus
package asfc_pkg;
  // ---------------------------------------------------------------
  // character modes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ASFC_MODE_7BIT = 3'h0,
    ASFC_MODE_8BIT = 3'h1,
    ASFC_MODE_8EVEN = 3'h2,
    ASFC_MODE_8ODD = 3'h3,
    ASFC_MODE_8ADDR = 3'h4
  } asfc_mode_t;

  // ---------------------------------------------------------------
  // widths and counts
  // ---------------------------------------------------------------
  localparam int ASFC_DIV_W = 16;
  localparam int ASFC_DATA_W = 9;
  localparam int ASFC_BIT_W = 4;
  localparam logic [3:0] ASFC_BITS_7 = 4'h7;
  localparam logic [3:0] ASFC_BITS_8 = 4'h8;
  localparam logic [ASFC_DIV_W-1:0] ASFC_DIV_ONE = 16'h0001;
  localparam logic [ASFC_DIV_W-1:0] ASFC_DIV_ZERO = 16'h0000;
  localparam logic [1:0] ASFC_STOP_ONE = 2'h1;
  localparam logic [1:0] ASFC_STOP_TWO = 2'h2;

  // line configuration shared by both directions
  typedef struct packed {
    asfc_mode_t mode;
    logic two_stop;
    logic [ASFC_DIV_W-1:0] baud_divisor;
  } asfc_cfg_t;

  // word with ninth bit (address flag on receive, zero in other modes; parity errors go to parity_err)
  typedef struct packed {
    logic ninth;
    logic [7:0] data;
  } asfc_word_t;

  // receive word with status
  typedef struct packed {
    logic framing_err;
    logic parity_err;
    asfc_word_t word;
  } asfc_rx_t;

  typedef enum logic [2:0] {
    ASFC_IDLE = 3'b000,
    ASFC_START = 3'b001,
    ASFC_DATA = 3'b011,
    ASFC_NINTH = 3'b010,
    ASFC_STOP = 3'b110
  } asfc_state_t;
endpackage
